// file: core/pnpp_pkg.sv
// constants and types shared by the parallel programming port
package pnpp_pkg;
	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int ENTRY_HOLD_NS = 100;
	localparam int ENTRY_HOLD_CYC = (ENTRY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FUSE_PROG_NS = 4500;
	localparam int FUSE_PROG_CYC = (FUSE_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ENTRY_TOGGLES = 6;
	localparam int TIMER_W = 9;

	// ****************************************************************
	// synchronised pin vector layout
	// ****************************************************************
	localparam int PIN_XTAL = 0;
	localparam int PIN_XA0 = 1;
	localparam int PIN_XA1 = 2;
	localparam int PIN_BS1 = 3;
	localparam int PIN_BS2 = 4;
	localparam int PIN_PAGE_LOAD_STROBE = 5;
	localparam int PIN_WRN = 6;
	localparam int PIN_OEN = 7;
	localparam int PIN_RSTLOW = 8;
	localparam int PIN_RSTHV = 9;
	localparam int DATA_LSB = 10;
	localparam int PIN_W = 18;

	// ****************************************************************
	// codes
	// ****************************************************************
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD = 2'h2;
	localparam logic [1:0] SEL_LO = 2'h0;
	localparam logic [1:0] SEL_HI = 2'h1;
	localparam logic [1:0] SEL_EXT = 2'h2;
	localparam logic [1:0] SEL_RSV = 2'h3;

	localparam logic [7:0] CMD_NOP = 8'h00;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [7:0] CMD_WR_FUSE = 8'h40;
	localparam logic [7:0] CMD_WR_LOCK = 8'h20;
	localparam logic [7:0] CMD_WR_FLASH = 8'h10;
	localparam logic [7:0] CMD_WR_EE = 8'h11;
	localparam logic [7:0] CMD_RD_SIG = 8'h08;
	localparam logic [7:0] CMD_RD_FUSE = 8'h04;
	localparam logic [7:0] CMD_RD_FLASH = 8'h02;
	localparam logic [7:0] CMD_RD_EE = 8'h03;

	// ****************************************************************
	// fuse, lock and page layout
	// ****************************************************************
	localparam logic [7:0] FUSE_LOW_RST = 8'h5e;
	localparam logic [7:0] FUSE_HIGH_RST = 8'hd9;
	localparam logic [7:0] FUSE_EXT_RST = 8'hf4;
	localparam logic [7:0] LOCK_RST = 8'hff;
	localparam int EEPROM_PRESERVE_FUSE_BIT = 3;
	localparam int MAX_PAGE_BITS = 6;
	localparam int EE_PAGE_BITS = 2;
	localparam logic [15:0] FILL_WORD = 16'hffff;

	typedef enum logic [2:0]
	{
		ST_OFF = 3'h0,
		ST_SETTLE = 3'h1,
		ST_IDLE = 3'h3,
		ST_PAGE_ISSUE = 3'h2,
		ST_PAGE_WAIT = 3'h6,
		ST_ERASE_WAIT = 3'h7,
		ST_FUSE_WAIT = 3'h5,
		ST_FAIL = 3'h4
	} pnpp_state_e;

	typedef enum logic [2:0]
	{
		MEM_NONE = 3'h0,
		MEM_RD_FLASH = 3'h1,
		MEM_RD_EE = 3'h2,
		MEM_RD_SIG = 3'h3,
		MEM_WR_FLASH = 3'h4,
		MEM_WR_EE = 3'h5,
		MEM_ERASE = 3'h6
	} pnpp_mem_e;
endpackage

// file: core/pnpp_pins_if.sv
// synchronised pin levels and edges passed from the pin stage to the core
`timescale 1ns/1ns
interface pnpp_pins_if;
	logic [pnpp_pkg::PIN_W-1:0] level;
	logic [pnpp_pkg::PIN_W-1:0] rise;
	logic [pnpp_pkg::PIN_W-1:0] fall;
	modport drv (output level, output rise, output fall);
	modport core (input level, input rise, input fall);
endinterface

// file: core/pnpp_pin_sync.sv
// two-flop synchronisers and edge detectors for the programming pins
`timescale 1ns/1ns
module pnpp_pin_sync
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [pnpp_pkg::PIN_W-1:0] pins,
	pnpp_pins_if.drv sync
);
	logic [pnpp_pkg::PIN_W-1:0] meta;
	logic [pnpp_pkg::PIN_W-1:0] stable;
	logic [pnpp_pkg::PIN_W-1:0] prev;

	genvar i;
	generate
		for (i = 0; i < pnpp_pkg::PIN_W; i++)
		begin : g_pin
			// meta feeds stable only; edges compare stable with prev
			always_ff @(posedge clock or posedge rst)
			begin
				if (rst)
				begin
					meta[i] <= 1'b0;
					stable[i] <= 1'b0;
					prev[i] <= 1'b0;
				end
				else
				begin
					meta[i] <= pins[i];
					stable[i] <= meta[i];
					prev[i] <= stable[i];
				end
			end
		end
	endgenerate

	assign sync.level = stable;
	assign sync.rise = stable & ~prev;
	assign sync.fall = ~stable & prev;
endmodule

// file: core/pnpp_core.sv
// parallel high-voltage programming port: entry, command decode, page buffer
`timescale 1ns/1ns
module pnpp_core
#(
	parameter int PAGE_BITS = 6
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic crystalLoadStrobe,
	input wire logic strobeAction0,
	input wire logic strobeAction1,
	input wire logic byteSelectLo,
	input wire logic byteSelectHi,
	input wire logic pageLoadStrobe,
	input wire logic writeStrobeN,
	input wire logic outputEnableN,
	input wire logic resetPinLow,
	input wire logic resetPinHigh,
	input wire logic [7:0] dataIn,
	output logic [7:0] dataOut,
	output logic dataOe,
	output logic readyBusyOut,
	output logic progMode,
	output logic memStart,
	output pnpp_pkg::pnpp_mem_e memOp,
	output logic [23:0] memAddr,
	output logic [15:0] memWdata,
	output logic memKeepEeprom,
	input wire logic memDone,
	input wire logic [15:0] memRdData
);
	// ****************************************************************
	// pin synchronisation
	// ****************************************************************
	localparam int PB = pnpp_pkg::MAX_PAGE_BITS;
	localparam int PAGE_WORDS = 1 << PB;
	localparam logic [PB-1:0] FLASH_MASK = PB'((1 << PAGE_BITS) - 1);
	localparam logic [PB-1:0] EE_MASK = PB'((1 << pnpp_pkg::EE_PAGE_BITS) - 1);
	localparam logic [pnpp_pkg::TIMER_W-1:0] HOLD_LAST =
		pnpp_pkg::TIMER_W'(pnpp_pkg::ENTRY_HOLD_CYC - 1);
	localparam logic [pnpp_pkg::TIMER_W-1:0] FUSE_LAST =
		pnpp_pkg::TIMER_W'(pnpp_pkg::FUSE_PROG_CYC - 1);
	localparam logic [2:0] TOGGLES = 3'(pnpp_pkg::ENTRY_TOGGLES);

	pnpp_pins_if pinsIf();
	wire [pnpp_pkg::PIN_W-1:0] pinVec = {dataIn, resetPinHigh, resetPinLow, outputEnableN,
		writeStrobeN, pageLoadStrobe, byteSelectHi, byteSelectLo, strobeAction1, strobeAction0,
		crystalLoadStrobe};

	pnpp_pin_sync u_sync
	(
		.clock(clock),
		.rst(rst),
		.pins(pinVec),
		.sync(pinsIf)
	);

	// ****************************************************************
	// decoding
	// ****************************************************************
	function automatic pnpp_pkg::pnpp_mem_e readOp(input logic [7:0] c);
		pnpp_pkg::pnpp_mem_e op;
		op = pnpp_pkg::MEM_NONE;
		case (c)
			pnpp_pkg::CMD_RD_FLASH: op = pnpp_pkg::MEM_RD_FLASH;
			pnpp_pkg::CMD_RD_EE: op = pnpp_pkg::MEM_RD_EE;
			pnpp_pkg::CMD_RD_SIG: op = pnpp_pkg::MEM_RD_SIG;
			default: op = pnpp_pkg::MEM_NONE;
		endcase
		return op;
	endfunction

	pnpp_pkg::pnpp_state_e state;
	pnpp_pkg::pnpp_state_e next_state;
	logic [2:0] toggleCnt;
	logic [pnpp_pkg::TIMER_W-1:0] timer;
	logic [7:0] cmd;
	logic [23:0] addr;
	logic [7:0] dataLo;
	logic [7:0] dataHi;
	logic [7:0] fuseLow;
	logic [7:0] fuseHigh;
	logic [7:0] fuseExt;
	logic [7:0] lockBits;
	logic [PB-1:0] wordIdx;
	logic [15:0] pageBuf [PAGE_WORDS];

	wire xtalRise = pinsIf.rise[pnpp_pkg::PIN_XTAL];
	wire xtalToggle = xtalRise | pinsIf.fall[pnpp_pkg::PIN_XTAL];
	wire pagelRise = pinsIf.rise[pnpp_pkg::PIN_PAGE_LOAD_STROBE];
	wire wrFall = pinsIf.fall[pnpp_pkg::PIN_WRN];
	wire oeActive = ~pinsIf.level[pnpp_pkg::PIN_OEN];
	wire rstLow = pinsIf.level[pnpp_pkg::PIN_RSTLOW];
	wire hvOn = pinsIf.level[pnpp_pkg::PIN_RSTHV];
	wire [1:0] action = {pinsIf.level[pnpp_pkg::PIN_XA1], pinsIf.level[pnpp_pkg::PIN_XA0]};
	wire [1:0] sel = {pinsIf.level[pnpp_pkg::PIN_BS2], pinsIf.level[pnpp_pkg::PIN_BS1]};
	wire bs1 = pinsIf.level[pnpp_pkg::PIN_BS1];
	wire [7:0] busData = pinsIf.level[pnpp_pkg::DATA_LSB +: 8];
	wire [3:0] progEnable = {pinsIf.level[pnpp_pkg::PIN_PAGE_LOAD_STROBE], action, bs1};

	wire inIdle = (state == pnpp_pkg::ST_IDLE);
	wire inMode = !(state inside {pnpp_pkg::ST_OFF, pnpp_pkg::ST_SETTLE, pnpp_pkg::ST_FAIL});
	wire busy = inMode && !inIdle;
	wire isEe = (cmd == pnpp_pkg::CMD_WR_EE);
	wire isPageCmd = (cmd == pnpp_pkg::CMD_WR_FLASH) || isEe;
	wire loadStrobe = inIdle && xtalRise;
	wire wrErase = inIdle && wrFall && (cmd == pnpp_pkg::CMD_ERASE);
	wire wrFuse = inIdle && wrFall && (cmd == pnpp_pkg::CMD_WR_FUSE) &&
		(sel != pnpp_pkg::SEL_RSV);
	wire wrLock = inIdle && wrFall && (cmd == pnpp_pkg::CMD_WR_LOCK);
	wire wrPage = inIdle && wrFall && isPageCmd && (sel == pnpp_pkg::SEL_LO);
	wire [PB-1:0] curMask = isEe ? EE_MASK : FLASH_MASK;
	wire [PB-1:0] latchIdx = addr[PB-1:0] & curMask;
	wire lastWord = (wordIdx == curMask);
	wire [23:0] pageAddr = (addr & ~{18'h0, curMask}) | {18'h0, wordIdx};
	wire pageDone = (state == pnpp_pkg::ST_PAGE_WAIT) && memDone && lastWord;

	// ****************************************************************
	// read data selection
	// ****************************************************************
	logic [7:0] readByte;
	always_comb
	begin
		readByte = 8'h00;
		case (cmd)
			pnpp_pkg::CMD_RD_FUSE:
				case (sel)
					pnpp_pkg::SEL_LO: readByte = fuseLow;
					pnpp_pkg::SEL_HI: readByte = lockBits;
					pnpp_pkg::SEL_EXT: readByte = fuseExt;
					default: readByte = fuseHigh;
				endcase
			pnpp_pkg::CMD_RD_FLASH, pnpp_pkg::CMD_RD_SIG:
				readByte = bs1 ? memRdData[15:8] : memRdData[7:0];
			pnpp_pkg::CMD_RD_EE: readByte = memRdData[7:0];
			default: readByte = 8'h00;
		endcase
	end

	// ****************************************************************
	// sequencing
	// ****************************************************************
	always_comb
	begin
		next_state = state;
		case (state)
			pnpp_pkg::ST_OFF:
				if (hvOn && toggleCnt == TOGGLES)
					next_state = pnpp_pkg::ST_SETTLE;
			pnpp_pkg::ST_SETTLE:
				if (progEnable != 4'h0)
					next_state = pnpp_pkg::ST_FAIL;
				else if (timer == HOLD_LAST)
					next_state = pnpp_pkg::ST_IDLE;
			pnpp_pkg::ST_IDLE:
				if (wrErase)
					next_state = pnpp_pkg::ST_ERASE_WAIT;
				else if (wrFuse || wrLock)
					next_state = pnpp_pkg::ST_FUSE_WAIT;
				else if (wrPage)
					next_state = pnpp_pkg::ST_PAGE_ISSUE;
			pnpp_pkg::ST_PAGE_ISSUE:
				next_state = pnpp_pkg::ST_PAGE_WAIT;
			pnpp_pkg::ST_PAGE_WAIT:
				if (memDone)
					next_state = lastWord ? pnpp_pkg::ST_IDLE : pnpp_pkg::ST_PAGE_ISSUE;
			pnpp_pkg::ST_ERASE_WAIT:
				if (memDone)
					next_state = pnpp_pkg::ST_IDLE;
			pnpp_pkg::ST_FUSE_WAIT:
				if (timer == FUSE_LAST)
					next_state = pnpp_pkg::ST_IDLE;
			pnpp_pkg::ST_FAIL:
				next_state = pnpp_pkg::ST_FAIL;
			default:
				next_state = pnpp_pkg::ST_OFF;
		endcase
		// dropping the high voltage always leaves programming mode
		if (!hvOn)
			next_state = pnpp_pkg::ST_OFF;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state <= pnpp_pkg::ST_OFF;
			timer <= '0;
			toggleCnt <= 3'h0;
			wordIdx <= '0;
		end
		else
		begin
			state <= next_state;
			timer <= (next_state != state) ? '0 : timer + 1'b1;
			if (state != pnpp_pkg::ST_OFF)
				toggleCnt <= 3'h0;
			else if (rstLow && xtalToggle && toggleCnt != TOGGLES)
				toggleCnt <= toggleCnt + 3'h1;
			if (wrPage)
				wordIdx <= '0;
			else if (state == pnpp_pkg::ST_PAGE_WAIT && memDone)
				wordIdx <= wordIdx + 1'b1;
		end
	end

	// ****************************************************************
	// command, address and data latches; held until reloaded
	// ****************************************************************
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			cmd <= pnpp_pkg::CMD_NOP;
			addr <= 24'h0;
			dataLo <= 8'h00;
			dataHi <= 8'h00;
		end
		else if (loadStrobe)
		begin
			if (action == pnpp_pkg::ACT_CMD)
				cmd <= busData;
			if (action == pnpp_pkg::ACT_ADDR && sel == pnpp_pkg::SEL_LO)
				addr[7:0] <= busData;
			if (action == pnpp_pkg::ACT_ADDR && sel == pnpp_pkg::SEL_HI)
				addr[15:8] <= busData;
			if (action == pnpp_pkg::ACT_ADDR && sel == pnpp_pkg::SEL_EXT)
				addr[23:16] <= busData;
			if (action == pnpp_pkg::ACT_DATA && !bs1)
				dataLo <= busData;
			if (action == pnpp_pkg::ACT_DATA && bs1)
				dataHi <= busData;
		end
	end

	// ****************************************************************
	// fuse and lock bits; lock bits only ever return to ones through an erase
	// ****************************************************************
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			fuseLow <= pnpp_pkg::FUSE_LOW_RST;
			fuseHigh <= pnpp_pkg::FUSE_HIGH_RST;
			fuseExt <= pnpp_pkg::FUSE_EXT_RST;
			lockBits <= pnpp_pkg::LOCK_RST;
		end
		else
		begin
			if (wrFuse && sel == pnpp_pkg::SEL_LO)
				fuseLow <= dataLo;
			if (wrFuse && sel == pnpp_pkg::SEL_HI)
				fuseHigh <= dataLo;
			if (wrFuse && sel == pnpp_pkg::SEL_EXT)
				fuseExt <= dataLo;
			if (wrLock)
				lockBits <= lockBits & dataLo;
			else if (state == pnpp_pkg::ST_ERASE_WAIT && memDone)
				lockBits <= pnpp_pkg::LOCK_RST;
		end
	end

	// ****************************************************************
	// page buffer; refilled with erased words so unloaded slots are harmless
	// ****************************************************************
	always_ff @(posedge clock)
	begin
		if (pageDone || state == pnpp_pkg::ST_SETTLE)
			for (int k = 0; k < PAGE_WORDS; k++)
				pageBuf[k] <= pnpp_pkg::FILL_WORD;
		else if (inIdle && pagelRise && isPageCmd)
			pageBuf[latchIdx] <= isEe ? {8'hff, dataLo} : {dataHi, dataLo};
	end

	// ****************************************************************
	// registered outputs
	// ****************************************************************
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			memStart <= 1'b0;
			memOp <= pnpp_pkg::MEM_NONE;
			memAddr <= 24'h0;
			memWdata <= 16'h0;
			memKeepEeprom <= 1'b0;
			dataOut <= 8'h00;
			dataOe <= 1'b0;
			readyBusyOut <= 1'b1;
			progMode <= 1'b0;
		end
		else
		begin
			memStart <= wrErase || (state == pnpp_pkg::ST_PAGE_ISSUE);
			memKeepEeprom <= ~fuseHigh[pnpp_pkg::EEPROM_PRESERVE_FUSE_BIT];
			if (wrErase)
				memOp <= pnpp_pkg::MEM_ERASE;
			else if (state == pnpp_pkg::ST_PAGE_ISSUE)
				memOp <= isEe ? pnpp_pkg::MEM_WR_EE : pnpp_pkg::MEM_WR_FLASH;
			else if (inIdle)
				memOp <= readOp(cmd);
			memAddr <= (state == pnpp_pkg::ST_PAGE_ISSUE) ? pageAddr : addr;
			memWdata <= inMode ? pageBuf[wordIdx] : 16'h0;
			dataOut <= readByte;
			dataOe <= inMode && oeActive;
			readyBusyOut <= !(busy || wrErase || wrFuse || wrLock || wrPage);
			progMode <= inMode;
		end
	end
endmodule

// file: bench/pnpp_core_chk.sv
// assertions on the programming port pins and the memory port
`timescale 1ns/1ns
module pnpp_core_chk
#(
	parameter int PAGE_BITS = 6
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic pageLoadStrobe,
	input wire logic outputEnableN,
	input wire logic resetPinHigh,
	input wire logic dataOe,
	input wire logic readyBusyOut,
	input wire logic progMode,
	input wire logic memStart,
	input wire pnpp_pkg::pnpp_mem_e memOp,
	input wire logic [23:0] memAddr,
	input wire logic memDone
);
	logic [23:0] lastAddr;
	pnpp_pkg::pnpp_mem_e lastOp;
	logic lastWord;
	// keep the word in flight: memAddr may move on before memDone
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			lastAddr <= 24'h0;
			lastOp <= pnpp_pkg::MEM_NONE;
		end
		else if (memStart)
		begin
			lastAddr <= memAddr;
			lastOp <= memOp;
		end
	end
	assign lastWord = lastOp == pnpp_pkg::MEM_WR_FLASH ? &lastAddr[PAGE_BITS-1:0] :
		lastOp == pnpp_pkg::MEM_WR_EE ? &lastAddr[1:0] : 1'b1;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	a_busy_at_start: assert property (memStart |-> !readyBusyOut)
		else $error("ready high at memory start");
	a_start_one_pulse: assert property (memStart |=> !memStart)
		else $error("memory start too long");
	a_page_word_step: assert property (memStart && memOp == pnpp_pkg::MEM_WR_FLASH
		&& memAddr[PAGE_BITS-1:0] != '0 |-> memAddr == lastAddr + 24'h1)
		else $error("page word address skipped");
	a_busy_mid_page: assert property (memDone && !lastWord |=> !readyBusyOut)
		else $error("ready before page end");
	a_ready_after_last: assert property (memDone && lastWord |-> ##2 readyBusyOut)
		else $error("ready late after last word");
	a_bus_released: assert property (outputEnableN [*4] |=> !dataOe)
		else $error("bus driven with output enable high");
	a_bus_driven: assert property ((progMode && resetPinHigh && !outputEnableN) [*5] |-> dataOe)
		else $error("bus not driven with output enable low");
	a_quiet_outside: assert property (!progMode [*2] |-> !memStart && !dataOe)
		else $error("activity outside programming mode");
	a_entry_refused: assert property ($rose(resetPinHigh) ##1
		(resetPinHigh && pageLoadStrobe) [*8] |=> !progMode [*8])
		else $error("entry taken with moving pins");

	c_erase: cover property (memStart && memOp == pnpp_pkg::MEM_ERASE);
	c_page: cover property (memDone && lastWord && lastOp == pnpp_pkg::MEM_WR_FLASH);
	c_entry: cover property ($rose(progMode));
endmodule

// file: bench/pnpp_prog.sv
// programmer model driving the parallel programming pins
`timescale 1ns/1ns
module pnpp_prog
(
	input wire logic clock,
	input wire logic readyBusyOut,
	input wire logic dataOe,
	input wire logic [7:0] dataOut,
	output logic crystalLoadStrobe,
	output logic strobeAction0,
	output logic strobeAction1,
	output logic byteSelectLo,
	output logic byteSelectHi,
	output logic pageLoadStrobe,
	output logic writeStrobeN,
	output logic outputEnableN,
	output logic resetPinLow,
	output logic resetPinHigh,
	output logic [7:0] dataIn
);
	logic [7:0] busVal = 8'h00;
	// with output enable low, an undriven bus shows the inverse, so a stale byte cannot pass for a read
	assign dataIn = dataOe ? dataOut : (outputEnableN ? busVal : ~busVal);
	initial
	begin
		{crystalLoadStrobe, strobeAction0, strobeAction1, byteSelectLo, byteSelectHi} = 5'h00;
		{pageLoadStrobe, resetPinLow, resetPinHigh, writeStrobeN, outputEnableN} = 5'h03;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	// strobes last 25 clocks, the 250 ns minimum at 100 MHz
	task automatic load(input logic [1:0] act, input logic [1:0] sel, input logic [7:0] val);
		tick(1);
		{strobeAction1, strobeAction0} <= act;
		{byteSelectHi, byteSelectLo} <= sel;
		busVal <= val;
		tick(5);
		crystalLoadStrobe <= 1'b1;
		tick(25);
		crystalLoadStrobe <= 1'b0;
		tick(5);
	endtask
	task automatic latch();
		tick(1);
		pageLoadStrobe <= 1'b1;
		tick(25);
		pageLoadStrobe <= 1'b0;
		tick(5);
	endtask
	task automatic write(input logic [1:0] sel);
		tick(1);
		{byteSelectHi, byteSelectLo} <= sel;
		tick(5);
		writeStrobeN <= 1'b0;
		tick(25);
		writeStrobeN <= 1'b1;
		tick(5);
		for (int i = 0; i < 3000 && readyBusyOut !== 1'b1; i++)
			@(negedge clock);
	endtask
	task automatic read(input logic [1:0] sel, output logic [7:0] val);
		tick(1);
		{byteSelectHi, byteSelectLo} <= sel;
		outputEnableN <= 1'b0;
		tick(25);
		@(negedge clock);
		val = dataIn;
		tick(1);
		outputEnableN <= 1'b1;
		tick(6);
	endtask
	task automatic enter(input logic spoil);
		resetPinLow <= 1'b1;
		repeat (6)
		begin
			tick(5);
			crystalLoadStrobe <= ~crystalLoadStrobe;
		end
		{pageLoadStrobe, strobeAction1, strobeAction0, byteSelectLo} <= 4'h0;
		tick(10);
		resetPinLow <= 1'b0;
		resetPinHigh <= 1'b1;
		tick(1);
		pageLoadStrobe <= spoil;
		tick(20);
		pageLoadStrobe <= 1'b0;
		tick(5000);
	endtask
	task automatic leave();
		tick(1);
		resetPinHigh <= 1'b0;
		tick(10);
	endtask
endmodule

// file: bench/pnpp_core_tb.sv
// self-checking bench for the parallel programming port
`timescale 1ns/1ns
module pnpp_core_tb;
	localparam int PB = 5;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic crystalLoadStrobe, strobeAction0, strobeAction1, byteSelectLo, byteSelectHi;
	logic pageLoadStrobe, writeStrobeN, outputEnableN, resetPinLow, resetPinHigh;
	logic [7:0] dataIn, dataOut, got;
	logic dataOe, readyBusyOut, progMode, memStart, memKeepEeprom, keepSeen;
	logic memDone = 1'b0;
	pnpp_pkg::pnpp_mem_e memOp;
	logic [23:0] memAddr;
	logic [15:0] memWdata, memRdData;
	logic [15:0] flashMem [0:1023];
	int failures = 0;
	int cmpCount = 0;
	int memDly = 2;
	int busyCnt = 0;
	int startCnt = 0;
	int busySeen = 0;

	always #5 clock = ~clock;

	pnpp_core #(.PAGE_BITS(PB)) u_pnpp_core (.clock, .rst, .crystalLoadStrobe, .strobeAction0,
		.strobeAction1, .byteSelectLo, .byteSelectHi, .pageLoadStrobe, .writeStrobeN,
		.outputEnableN, .resetPinLow, .resetPinHigh, .dataIn, .dataOut, .dataOe, .readyBusyOut,
		.progMode, .memStart, .memOp, .memAddr, .memWdata, .memKeepEeprom, .memDone, .memRdData);
	pnpp_prog u_pnpp_prog (.clock, .readyBusyOut, .dataOe, .dataOut, .crystalLoadStrobe,
		.strobeAction0, .strobeAction1, .byteSelectLo, .byteSelectHi, .pageLoadStrobe,
		.writeStrobeN, .outputEnableN, .resetPinLow, .resetPinHigh, .dataIn);

	// far memory: answers memDly+1 clocks after memStart, reads are combinational
	assign memRdData = flashMem[memAddr[9:0]];
	always @(posedge clock)
	begin
		memDone <= busyCnt == 1;
		if (readyBusyOut === 1'b0)
			busySeen <= busySeen + 1;
		if (memStart)
		begin
			busyCnt <= memDly;
			startCnt <= startCnt + 1;
			keepSeen <= memKeepEeprom;
			if (memOp == pnpp_pkg::MEM_WR_FLASH || memOp == pnpp_pkg::MEM_WR_EE)
				flashMem[memAddr[9:0]] <= memWdata;
			if (memOp == pnpp_pkg::MEM_ERASE)
				foreach (flashMem[i]) flashMem[i] <= 16'hffff;
		end
		else if (busyCnt != 0)
			busyCnt <= busyCnt - 1;
	end

	task automatic checkVal(input string what, input logic [15:0] exp, input logic [15:0] seen);
		cmpCount++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic checkBit(input string what, input logic exp, input logic seen);
		checkVal(what, {15'h0000, exp}, {15'h0000, seen});
	endtask
	task automatic check_fuses(input logic [7:0] rd [4]);
		u_pnpp_prog.load(2'h2, 2'h0, pnpp_pkg::CMD_RD_FUSE);
		for (int s = 0; s < 4; s++)
		begin
			u_pnpp_prog.read(2'(s), got);
			checkVal("fuse or lock byte", {8'h00, rd[s]}, {8'h00, got});
		end
	endtask
	task automatic t_entry(input logic spoil);
		u_pnpp_prog.enter(spoil);
		checkBit("progMode", !spoil, progMode);
		checkBit("readyBusyOut", 1'b1, readyBusyOut);
	endtask
	task automatic t_fuse_lock();
		logic [7:0] wr [4] = '{8'h5c, 8'hd1, 8'hf5, 8'h00};
		int b0;
		u_pnpp_prog.load(2'h2, 2'h0, pnpp_pkg::CMD_WR_FUSE);
		for (int s = 0; s < 4; s++)
		begin
			b0 = busySeen;
			u_pnpp_prog.load(2'h1, 2'h0, wr[s]);
			u_pnpp_prog.write(2'(s));
			if (s == 0)
				checkBit("fuse busy", 1'b1, busySeen - b0 >= 440 && busySeen - b0 <= 460);
		end
		u_pnpp_prog.load(2'h2, 2'h0, pnpp_pkg::CMD_WR_LOCK);
		u_pnpp_prog.load(2'h1, 2'h0, 8'hfc);
		u_pnpp_prog.write(2'h0);
		check_fuses('{8'h5c, 8'hfc, 8'hf5, 8'hd1});
	endtask
	task automatic t_erase();
		int b0;
		memDly = 12;
		b0 = busySeen;
		u_pnpp_prog.load(2'h2, 2'h0, pnpp_pkg::CMD_ERASE);
		u_pnpp_prog.write(2'h0);
		checkBit("erase busy", 1'b1, busySeen - b0 >= 13);
		checkBit("memKeepEeprom", 1'b1, keepSeen);
		check_fuses('{8'h5c, 8'hff, 8'hf5, 8'hd1});
		memDly = 2;
	endtask
	task automatic t_page();
		int s0;
		u_pnpp_prog.load(2'h2, 2'h0, pnpp_pkg::CMD_WR_FLASH);
		u_pnpp_prog.load(2'h0, 2'h2, 8'h00);
		u_pnpp_prog.load(2'h0, 2'h1, 8'h01);
		for (int i = 0; i < 3; i++)
		begin
			u_pnpp_prog.load(2'h0, 2'h0, 8'h20 + 8'(i));
			u_pnpp_prog.load(2'h1, 2'h0, 8'ha0 + 8'(i));
			u_pnpp_prog.load(2'h1, 2'h1, 8'h50 + 8'(i));
			u_pnpp_prog.latch();
		end
		s0 = startCnt;
		u_pnpp_prog.write(2'h0);
		checkVal("page word starts", 16'(1 << PB), 16'(startCnt - s0));
		for (int i = 0; i < 3; i++)
			checkVal("flash word", {8'h50 + 8'(i), 8'ha0 + 8'(i)},
				flashMem[10'h120 + 10'(i)]);
		s0 = startCnt;
		u_pnpp_prog.load(2'h2, 2'h0, pnpp_pkg::CMD_NOP);
		u_pnpp_prog.write(2'h0);
		checkVal("starts after no-op", 16'h0000, 16'(startCnt - s0));
		u_pnpp_prog.load(2'h2, 2'h0, pnpp_pkg::CMD_RD_FLASH);
		u_pnpp_prog.load(2'h0, 2'h0, 8'h21);
		u_pnpp_prog.load(2'h3, 2'h0, 8'h22);
		u_pnpp_prog.read(2'h0, got);
		checkVal("flash low byte", 16'h00a1, {8'h00, got});
		u_pnpp_prog.read(2'h1, got);
		checkVal("flash high byte", 16'h0051, {8'h00, got});
		u_pnpp_prog.load(2'h2, 2'h0, pnpp_pkg::CMD_RD_EE);
		u_pnpp_prog.read(2'h0, got);
		checkVal("eeprom byte", 16'h00a1, {8'h00, got});
	endtask
	task automatic t_eeprom();
		int s0;
		u_pnpp_prog.load(2'h2, 2'h0, pnpp_pkg::CMD_WR_EE);
		u_pnpp_prog.load(2'h0, 2'h0, 8'h05);
		u_pnpp_prog.load(2'h1, 2'h0, 8'h77);
		u_pnpp_prog.latch();
		s0 = startCnt;
		u_pnpp_prog.write(2'h0);
		checkVal("eeprom starts", 16'(1 << pnpp_pkg::EE_PAGE_BITS), 16'(startCnt - s0));
		checkVal("eeprom written byte", 16'h0077, {8'h00, flashMem[10'h105][7:0]});
		checkVal("eeprom unloaded slot", 16'hffff, flashMem[10'h104]);
		u_pnpp_prog.load(2'h2, 2'h0, pnpp_pkg::CMD_RD_SIG);
		checkVal("memOp", 16'(pnpp_pkg::MEM_RD_SIG), 16'(memOp));
		u_pnpp_prog.read(2'h0, got);
		checkVal("signature byte", 16'h0077, {8'h00, got});
	endtask
	task automatic end_of_test();
		if (failures == 0 && cmpCount > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		t_entry(1'b1);
		u_pnpp_prog.leave();
		t_entry(1'b0);
		t_fuse_lock();
		t_erase();
		t_page();
		t_eeprom();
		end_of_test();
	end
	// the whole run needs about 14000 clocks
	initial
	begin
		repeat (60000) @(posedge clock);
		failures++;
		end_of_test();
	end
endmodule

bind pnpp_core pnpp_core_chk #(.PAGE_BITS(PAGE_BITS)) u_pnpp_core_chk (.clock, .rst,
	.pageLoadStrobe, .outputEnableN, .resetPinHigh, .dataOe, .readyBusyOut, .progMode,
	.memStart, .memOp, .memAddr, .memDone);
